// file: rtl/cecam_pkg.sv
// package for the bus controller configuration and address match block
// assumes an apb master on pclk, 32-bit data, word per register
package cecam_pkg;
	// register indices; byte address is four times the index
	localparam logic [17:0] IDX_CFG     = 18'h0_a080;
	localparam logic [17:0] IDX_ADR     = 18'h0_a081;
	localparam logic [17:0] IDX_STAT    = 18'h0_a090;
	localparam logic [17:0] IDX_TMO_LMT = 18'h0_a091;
	localparam int          ADDR_W      = 20;

	// reset values
	localparam logic [7:0] CFG_RST     = 8'h00;
	localparam logic [7:0] ADR_RST     = 8'h40;
	localparam logic [7:0] TMO_LMT_RST = 8'hff;

	// configuration / status / mask field positions
	localparam int B_TX_MODE  = 7;
	localparam int B_TX_CONT  = 6;
	localparam int B_START    = 5;
	localparam int B_TIMEOUT  = 4;
	localparam int B_LINE_ERR = 3;
	localparam int B_TX_ERR   = 2;
	localparam int B_TX_DONE  = 1;
	localparam int B_RX_DONE  = 0;
	localparam int N_FLAGS    = 6;

	// address register field positions
	localparam int B_FUNC_EN  = 7;
	localparam int B_ROLE_SW  = 6;
	localparam int B_ARB_LOST = 5;
	localparam int B_FIRST_BY = 4;
	localparam int B_LA_HI    = 3;
	localparam logic [3:0] BCAST_ADDR = 4'hf;

	// idle timeout tick
	localparam int CLK_MHZ    = 50;
	localparam int TICK_US    = 1;
	localparam int TICK_CYC   = TICK_US * CLK_MHZ;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
endpackage

// file: rtl/cecam_flag.sv
// one sticky event flag, hardware set beats software clear
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
module cecam_flag (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end
endmodule

// file: rtl/cecam_top.sv
// configuration, role control and address match of the cec line controller
// assumes a bit engine on pclk supplies the event pulses and idle level
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module cecam_top (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [cecam_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        cec_in,
	output logic                             cec_out,
	output logic                             cec_oe_n,
	input  wire logic                        bus_idle,
	input  wire logic                        start_detect,
	input  wire logic                        tx_start,
	input  wire logic                        dest_valid,
	input  wire logic [3:0]                  dest_addr,
	input  wire logic                        first_byte_rx,
	input  wire logic                        ack_slot,
	input  wire logic                        tx_drive_low,
	input  wire logic                        arb_lost,
	input  wire logic                        tx_error,
	input  wire logic                        line_error,
	input  wire logic                        tx_done,
	input  wire logic                        rx_done,
	output logic                             bus_function_enable,
	output logic                             tx_mode_select,
	output logic                             continuous_tx,
	output logic                             is_initiator,
	output logic                             tx_aborted,
	output logic                             line_level,
	output logic                             irq
);
	logic [7:0]         cfg_reg;
	logic [7:0]         adr_reg;
	logic [7:0]         tmo_lmt_reg;
	logic [7:0]         tick_cnt_reg;
	logic [7:0]         idle_cnt_reg;
	logic               switched_reg;
	logic               abort_reg;
	logic               match_reg;
	logic               drive_reg;
	logic               sync1_reg;
	logic               sync2_reg;
	logic [5:0]         stat;
	logic [5:0]         set_v;
	logic [5:0]         clr_v;
	logic [17:0]        idx;
	logic               setup;
	logic               acc;
	logic               wr;
	logic               rd;
	logic               mapped;
	logic               tick;
	logic               tmo_hit;
	logic               arb_lost_q;
	logic               first_q;
	logic               enabled;
	logic               lost_now;

	assign idx     = paddr[cecam_pkg::ADDR_W-1:2];
	assign mapped  = (idx == cecam_pkg::IDX_CFG) ||
	                 (idx == cecam_pkg::IDX_ADR) ||
	                 (idx == cecam_pkg::IDX_STAT) ||
	                 (idx == cecam_pkg::IDX_TMO_LMT);
	assign setup   = psel && !penable;
	assign acc     = psel && penable;
	assign wr      = acc && pwrite && mapped;
	assign rd      = acc && !pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	assign enabled = adr_reg[cecam_pkg::B_FUNC_EN];

	////////////////////////////////////////////////////////////////////////
	// line input synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= cec_in;
			sync2_reg <= sync1_reg;
		end
	end
	assign line_level = sync2_reg;

	////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= cecam_pkg::CFG_RST;
		end else if (wr && idx == cecam_pkg::IDX_CFG) begin
			cfg_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adr_reg <= cecam_pkg::ADR_RST;
		end else if (wr && idx == cecam_pkg::IDX_ADR) begin
			adr_reg <= {pwdata[7:6], 2'b00, pwdata[3:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmo_lmt_reg <= cecam_pkg::TMO_LMT_RST;
		end else if (wr && idx == cecam_pkg::IDX_TMO_LMT) begin
			tmo_lmt_reg <= pwdata[7:0];
		end
	end

	// read data latched in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= 32'h0000_0000;
			case (paddr[cecam_pkg::ADDR_W-1:2])
				cecam_pkg::IDX_CFG:     prdata[7:0] <= cfg_reg;
				cecam_pkg::IDX_ADR:     prdata[7:0] <= {adr_reg[7:6],
				                        arb_lost_q, first_q, adr_reg[3:0]};
				cecam_pkg::IDX_STAT:    prdata[5:0] <= stat;
				cecam_pkg::IDX_TMO_LMT: prdata[7:0] <= tmo_lmt_reg;
				default:                prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// role control
	assign tx_mode_select      = cfg_reg[cecam_pkg::B_TX_MODE];
	assign continuous_tx       = cfg_reg[cecam_pkg::B_TX_MODE] &&
	                             cfg_reg[cecam_pkg::B_TX_CONT];
	assign bus_function_enable = enabled;
	assign is_initiator        = enabled && tx_mode_select &&
	                             !switched_reg && !abort_reg;
	assign tx_aborted          = abort_reg;
	assign lost_now            = arb_lost && is_initiator;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switched_reg <= 1'b0;
		end else if (lost_now && adr_reg[cecam_pkg::B_ROLE_SW]) begin
			switched_reg <= 1'b1;
		end else if (bus_idle) begin
			switched_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_reg <= 1'b0;
		end else if (lost_now && !adr_reg[cecam_pkg::B_ROLE_SW]) begin
			abort_reg <= 1'b1;
		end else if (bus_idle) begin
			abort_reg <= 1'b0;
		end
	end

	// destination address compare
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_reg <= 1'b0;
		end else if (dest_valid) begin
			match_reg <= (dest_addr == adr_reg[cecam_pkg::B_LA_HI:0]) ||
			             (dest_addr == cecam_pkg::BCAST_ADDR);
		end else if (bus_idle) begin
			match_reg <= 1'b0;
		end
	end

	// open-drain drive, low level only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_reg <= 1'b0;
		end else begin
			drive_reg <= enabled && ((is_initiator && tx_drive_low) ||
			             (!is_initiator && !abort_reg && ack_slot &&
			              match_reg));
		end
	end
	assign cec_out  = 1'b0;
	assign cec_oe_n = !drive_reg;

	////////////////////////////////////////////////////////////////////////
	// hardware-cleared flags
	cecam_flag u_arb_flag (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (lost_now),
		.clr     (bus_idle),
		.q       (arb_lost_q)
	);

	cecam_flag u_first_flag (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (first_byte_rx && enabled),
		.clr     (bus_idle),
		.q       (first_q)
	);

	////////////////////////////////////////////////////////////////////////
	// idle timeout
	assign tick = (tick_cnt_reg == cecam_pkg::TICK_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= 8'h00;
		end else if (tick || !bus_idle) begin
			tick_cnt_reg <= 8'h00;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt_reg <= 8'h00;
		end else if (!bus_idle || !enabled) begin
			idle_cnt_reg <= 8'h00;
		end else if (tick && idle_cnt_reg != 8'hff) begin
			idle_cnt_reg <= idle_cnt_reg + 8'h01;
		end
	end
	assign tmo_hit = enabled && bus_idle && tick &&
	                 (idle_cnt_reg == tmo_lmt_reg) && (tmo_lmt_reg != 8'hff);

	////////////////////////////////////////////////////////////////////////
	// status flags and interrupt
	assign set_v[cecam_pkg::B_START]    = start_detect && enabled;
	assign set_v[cecam_pkg::B_TIMEOUT]  = tmo_hit;
	assign set_v[cecam_pkg::B_LINE_ERR] = line_error && enabled;
	assign set_v[cecam_pkg::B_TX_ERR]   = lost_now ||
	                                      (tx_error && enabled);
	assign set_v[cecam_pkg::B_TX_DONE]  = tx_done && enabled;
	assign set_v[cecam_pkg::B_RX_DONE]  = rx_done && enabled;

	// read clears, writing 0 clears a bit; new transfer clears timeout
	always_comb begin
		clr_v = 6'h00;
		if (rd && idx == cecam_pkg::IDX_STAT) begin
			clr_v = 6'h3f;
		end else if (wr && idx == cecam_pkg::IDX_STAT) begin
			clr_v = ~pwdata[5:0];
		end
		if (start_detect || tx_start) begin
			clr_v[cecam_pkg::B_TIMEOUT] = 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < cecam_pkg::N_FLAGS; gi = gi + 1) begin : g_flag
			cecam_flag u_flag (
				.pclk    (pclk),
				.presetn (presetn),
				.set     (set_v[gi]),
				.clr     (clr_v[gi]),
				.q       (stat[gi])
			);
		end
	endgenerate

	assign irq = |(stat & cfg_reg[5:0]);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_no_drive_off: assert property (!enabled |=> cec_oe_n)
		else $error("line driven while disabled");
	chk_auto_follow: assert property (
		lost_now && adr_reg[cecam_pkg::B_ROLE_SW] && !bus_idle |=>
		!is_initiator && !abort_reg)
		else $error("no switch to follower");
	chk_abort_hold: assert property (
		lost_now && !adr_reg[cecam_pkg::B_ROLE_SW] |=> abort_reg)
		else $error("no abort after arbitration loss");
	chk_arb_flag_idle: assert property (
		arb_lost_q && bus_idle && !lost_now |=> !arb_lost_q)
		else $error("arbitration flag kept over idle");
	chk_ack_match: assert property (
		!cec_oe_n && !$past(is_initiator) |-> $past(match_reg))
		else $error("acknowledge without address match");
	chk_irq_gate: assert property (
		irq |-> (stat & cfg_reg[5:0]) != 6'h00)
		else $error("interrupt from masked flag");
	chk_irq_raise: assert property (
		(set_v & cfg_reg[5:0]) != 6'h00 &&
		!(wr && idx == cecam_pkg::IDX_CFG) |=> irq)
		else $error("enabled event gave no interrupt");
	chk_txerr_set: assert property (
		lost_now |=> stat[cecam_pkg::B_TX_ERR])
		else $error("error flag not set on loss");
	chk_tmo_clear: assert property (
		tx_start && !tmo_hit |=> !stat[cecam_pkg::B_TIMEOUT])
		else $error("timeout flag survives new transfer");
	chk_cont_mode: assert property (
		continuous_tx |-> tx_mode_select)
		else $error("continuous transmit in receive mode");
endmodule

// file: tb/cecam_far_end.sv
// far-side device on the shared open-drain line
// assumes the dut pulls low while cec_oe_n is low; line has a pull-up
`timescale 1ns/1ps
module cecam_far_end (
	input  wire logic pclk,
	input  wire logic hold_low,
	input  wire logic dut_oe_n,
	output logic      wire_level
);
	logic pull_reg;

	always_ff @(posedge pclk) begin
		pull_reg <= hold_low;
	end

	// wired and, pull-up when nobody drives
	assign wire_level = ~pull_reg & dut_oe_n;
endmodule

// file: tb/cecam_top_tb.sv
// self-checking bench for the line controller configuration block
// assumes apb master here, event pulses from this bench, far end model
`timescale 1ns/1ps
module cecam_top_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        bus_idle, dest_valid, ack_slot, arb_lost, hold_low, err;
	logic        cec_in, cec_out, cec_oe_n, bus_function_enable;
	logic        tx_mode_select, continuous_tx, is_initiator, tx_aborted;
	logic        line_level, irq, drv, fb;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  dest_addr;
	logic [5:0]  ev;
	int          mismatches, comparisons;

	cecam_top i_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .cec_in, .cec_out, .cec_oe_n,
		.bus_idle, .start_detect(ev[5]), .tx_start(ev[4]), .dest_valid,
		.dest_addr, .first_byte_rx(fb), .ack_slot, .tx_drive_low(drv),
		.arb_lost, .tx_error(ev[2]), .line_error(ev[3]),
		.tx_done(ev[1]), .rx_done(ev[0]), .bus_function_enable,
		.tx_mode_select, .continuous_tx, .is_initiator, .tx_aborted,
		.line_level, .irq
	);

	cecam_far_end i_far (
		.pclk(pclk), .hold_low(hold_low), .dut_oe_n(cec_oe_n),
		.wire_level(cec_in)
	);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [17:0] idx,
			input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [17:0] idx,
			input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		chk(nm, rd, {24'h00_0000, e});
	endtask

	task automatic pulse(input logic [5:0] m, input logic a);
		@(posedge pclk);
		ev <= m;
		arb_lost <= a;
		@(posedge pclk);
		ev <= 6'h00;
		arb_lost <= 1'b0;
		@(negedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rdchk("cfg reset", cecam_pkg::IDX_CFG, 8'h00);
		rdchk("adr reset", cecam_pkg::IDX_ADR, 8'h40);
		apb(1'b0, 18'h0_a0ff, 8'h00);
		chk("unmapped err", err, 1'b1);
		chk("ready", pready, 1'b1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, cecam_pkg::IDX_CFG, {i[1:0], 6'h00});
			@(negedge pclk);
			chk("mode", tx_mode_select, i[1]);
			chk("continuous", continuous_tx, i == 3);
		end
		apb(1'b1, cecam_pkg::IDX_ADR, 8'hff);
		rdchk("adr ro bits", cecam_pkg::IDX_ADR, 8'hcf);
	endtask

	task automatic t_irq;
		int b;
		apb(1'b1, cecam_pkg::IDX_ADR, 8'h00);
		apb(1'b1, cecam_pkg::IDX_CFG, 8'h3f);
		pulse(6'h2f, 1'b0);
		rdchk("disabled status", cecam_pkg::IDX_STAT, 8'h00);
		apb(1'b1, cecam_pkg::IDX_ADR, 8'h80);
		for (int k = 0; k < 5; k++) begin
			b = (k < 4) ? k : 5;
			apb(1'b1, cecam_pkg::IDX_CFG, 8'h00);
			pulse(6'(1 << b), 1'b0);
			chk("masked irq", irq, 1'b0);
			rdchk("status", cecam_pkg::IDX_STAT, 8'(1 << b));
			apb(1'b1, cecam_pkg::IDX_CFG, 8'(1 << b));
			pulse(6'(1 << b), 1'b0);
			chk("enabled irq", irq, 1'b1);
			apb(1'b1, cecam_pkg::IDX_STAT, 8'h00);
			@(negedge pclk);
			chk("cleared irq", irq, 1'b0);
		end
	endtask

	task automatic t_ack(input logic [7:0] adr, input logic [3:0] dst,
			input logic exp);
		apb(1'b1, cecam_pkg::IDX_CFG, 8'h00);
		apb(1'b1, cecam_pkg::IDX_ADR, adr);
		@(posedge pclk);
		bus_idle <= 1'b0;
		dest_valid <= 1'b1;
		dest_addr <= dst;
		@(posedge pclk);
		dest_valid <= 1'b0;
		ack_slot <= 1'b1;
		@(posedge pclk);
		ack_slot <= 1'b0;
		@(negedge pclk);
		chk("ack drive", cec_oe_n, !exp);
		chk("line out", cec_out, 1'b0);
		chk("function enable", bus_function_enable, adr[7]);
		@(posedge pclk);
		bus_idle <= 1'b1;
	endtask

	task automatic t_arb(input logic sw);
		apb(1'b1, cecam_pkg::IDX_CFG, 8'h84);
		apb(1'b1, cecam_pkg::IDX_ADR, {1'b1, sw, 6'h03});
		@(posedge pclk);
		bus_idle <= 1'b0;
		@(negedge pclk);
		chk("initiator", is_initiator, 1'b1);
		@(posedge pclk);
		drv <= 1'b1;
		fb <= 1'b1;
		@(posedge pclk);
		drv <= 1'b0;
		fb <= 1'b0;
		@(negedge pclk);
		chk("initiator drive", cec_oe_n, 1'b0);
		pulse(6'h00, 1'b1);
		chk("role", is_initiator, 1'b0);
		chk("aborted", tx_aborted, !sw);
		chk("err irq", irq, 1'b1);
		rdchk("arb flag", cecam_pkg::IDX_ADR, {1'b1, sw, 6'h33});
		rdchk("err status", cecam_pkg::IDX_STAT, 8'h04);
		@(posedge pclk);
		bus_idle <= 1'b1;
		repeat (2) @(negedge pclk);
		chk("abort ends", tx_aborted, 1'b0);
		rdchk("arb cleared", cecam_pkg::IDX_ADR, {1'b1, sw, 6'h03});
	endtask

	task automatic t_tmo;
		int n;
		apb(1'b1, cecam_pkg::IDX_ADR, 8'h80);
		apb(1'b1, cecam_pkg::IDX_CFG, 8'h10);
		@(posedge pclk);
		bus_idle <= 1'b0;
		apb(1'b1, cecam_pkg::IDX_TMO_LMT, 8'h02);
		@(posedge pclk);
		bus_idle <= 1'b1;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (irq !== 1'b1 && n < 400);
		chk("timeout window", n > 100 && n <= 200, 1'b1);
		@(posedge pclk);
		bus_idle <= 1'b0;
		pulse(6'h10, 1'b0);
		chk("timeout clear", irq, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge pclk);
		mismatches++;
		wrap_up();
	end

	initial begin
		{presetn, psel, penable, pwrite, dest_valid, ack_slot} = 6'h00;
		{arb_lost, hold_low, drv, fb, ev, dest_addr} = 14'h0000;
		{paddr, pwdata} = 52'h0_0000_0000_0000;
		bus_idle = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		$display("test registers done");
		t_irq();
		$display("test interrupts done");
		t_ack(8'h85, 4'h5, 1'b1);
		t_ack(8'h85, 4'hf, 1'b1);
		t_ack(8'h85, 4'h3, 1'b0);
		t_ack(8'h05, 4'h5, 1'b0);
		$display("test address match done");
		t_arb(1'b1);
		t_arb(1'b0);
		$display("test arbitration done");
		t_tmo();
		$display("test timeout done");
		@(posedge pclk);
		hold_low <= 1'b1;
		repeat (4) @(negedge pclk);
		chk("line level", line_level, 1'b0);
		wrap_up();
	end
endmodule
